// [shared/result_readout_defines.vh]
// Constants for the magnetometer result readout block.
// Assumes byte-wide register addresses from the serial interface.
`ifndef RESULT_READOUT_DEFINES_VH
`define RESULT_READOUT_DEFINES_VH

// Register addresses
`define ADDR_IDENT 8'h40
`define ADDR_RSVD 8'h41
`define ADDR_X_LOW 8'h42
`define ADDR_X_HIGH 8'h43
`define ADDR_Y_LOW 8'h44
`define ADDR_Y_HIGH 8'h45
`define ADDR_Z_LOW 8'h46
`define ADDR_Z_HIGH 8'h47
`define ADDR_R_LOW 8'h48
`define ADDR_R_HIGH 8'h49
`define ADDR_INT_FLAGS 8'h4A

// Result widths
`define XY_WIDTH 13
`define Z_WIDTH 15
`define R_WIDTH 14

// Reset and fixed values
`define BYTE_ZERO 8'h00
`define CHECK_DEFAULT 1'b1
`define ADDR_ZERO 8'h00
// Arbitrary neutral identification value
`define IDENT_VALUE 8'hA5

`endif

// [src/sample_hold.v]
// Holds one axis result plus its check flag.
// Assumes load strobes come from logic on core_clk.
module sample_hold #(
   parameter WIDTH = 13
) (
   // Clock and reset
   input wire core_clk,
   input wire rst_b,
   // New sample
   input wire load,
   input wire clearValue,
   input wire [WIDTH-1:0] newValue,
   input wire loadCheck,
   input wire newCheck,
   // Held result
   output reg [WIDTH-1:0] value,
   output reg checkFlag
);

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         value <= {WIDTH{1'b0}};
         checkFlag <= 1'b1;
      end else begin
         if (clearValue) begin
            value <= {WIDTH{1'b0}};
         end else if (load) begin
            value <= newValue;
         end
         if (loadCheck) begin
            checkFlag <= newCheck;
         end
      end
   end

endmodule

// [src/magnetometer_result_readout.v]
// Read-only result and status registers of the three-axis field sensor.
// Assumes the serial interface issues single-cycle reads on core_clk and
// that measurement logic delivers samples as one-cycle strobes.
`include "result_readout_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module magnetometer_result_readout (
   // Clock and reset
   input wire core_clk,
   input wire rst_b,
   // Control from the device core
   input wire powerControl,
   input wire xEnable,
   input wire yEnable,
   input wire zEnable,
   // New measurement sample
   input wire sampleStrobe,
   input wire [`XY_WIDTH-1:0] xSample,
   input wire [`XY_WIDTH-1:0] ySample,
   input wire [`Z_WIDTH-1:0] zSample,
   input wire [`R_WIDTH-1:0] rSample,
   // Self-test outcome
   input wire checkStrobe,
   input wire xCheck,
   input wire yCheck,
   input wire zCheck,
   // Status from the interrupt engine
   input wire readyStatus,
   input wire [7:0] intStatus,
   // Register read port
   input wire readStrobe,
   input wire burstActive,
   input wire [7:0] readAddr,
   output reg [7:0] readData,
   output wire suspended
);

   ////////////////////////////////////////////////////////////////////////////
   // Shadow copies of the live results

   wire [`XY_WIDTH-1:0] xLive;
   wire [`XY_WIDTH-1:0] yLive;
   wire [`Z_WIDTH-1:0] zLive;
   wire [`R_WIDTH-1:0] rLive;
   wire xCheckLive;
   wire yCheckLive;
   wire zCheckLive;
   wire unusedCheck;

   // Samples only land while powered; in suspend ~zEnable still clears the R result
   wire takeSample = sampleStrobe & powerControl;
   wire takeCheck = checkStrobe & powerControl;

   sample_hold #(.WIDTH(`XY_WIDTH)) xHold (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .load(takeSample & xEnable),
      .clearValue(1'b0),
      .newValue(xSample),
      .loadCheck(takeCheck),
      .newCheck(xCheck),
      .value(xLive),
      .checkFlag(xCheckLive)
   );

   sample_hold #(.WIDTH(`XY_WIDTH)) yHold (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .load(takeSample & yEnable),
      .clearValue(1'b0),
      .newValue(ySample),
      .loadCheck(takeCheck),
      .newCheck(yCheck),
      .value(yLive),
      .checkFlag(yCheckLive)
   );

   sample_hold #(.WIDTH(`Z_WIDTH)) zHold (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .load(takeSample & zEnable),
      .clearValue(1'b0),
      .newValue(zSample),
      .loadCheck(takeCheck),
      .newCheck(zCheck),
      .value(zLive),
      .checkFlag(zCheckLive)
   );

   sample_hold #(.WIDTH(`R_WIDTH)) rHold (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .load(takeSample),
      .clearValue(~zEnable),
      .newValue(rSample),
      .loadCheck(1'b0),
      .newCheck(1'b0),
      .value(rLive),
      .checkFlag(unusedCheck)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Snapshot frozen for the length of a burst

   // Without it a sample landing mid-burst could pair old low with new high
   reg burstSeen;
   reg [`XY_WIDTH-1:0] xSnap;
   reg [`XY_WIDTH-1:0] ySnap;
   reg [`Z_WIDTH-1:0] zSnap;
   reg [`R_WIDTH-1:0] rSnap;
   reg [2:0] checkSnap;

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         burstSeen <= 1'b0;
         xSnap <= {`XY_WIDTH{1'b0}};
         ySnap <= {`XY_WIDTH{1'b0}};
         zSnap <= {`Z_WIDTH{1'b0}};
         rSnap <= {`R_WIDTH{1'b0}};
         checkSnap <= {3{`CHECK_DEFAULT}};
      end else begin
         burstSeen <= burstActive;
         if (!burstActive) begin
            xSnap <= xLive;
            ySnap <= yLive;
            zSnap <= zLive;
            rSnap <= rLive;
            checkSnap <= {zCheckLive, yCheckLive, xCheckLive};
         end
      end
   end

   // Before the first cycle of a burst the snapshot tracks live values
   wire useSnap = burstActive & burstSeen;
   wire [`XY_WIDTH-1:0] xView = useSnap ? xSnap : xLive;
   wire [`XY_WIDTH-1:0] yView = useSnap ? ySnap : yLive;
   wire [`Z_WIDTH-1:0] zView = useSnap ? zSnap : zLive;
   wire [`R_WIDTH-1:0] rView = useSnap ? rSnap : rLive;
   wire [2:0] checkView = useSnap ? checkSnap : {zCheckLive, yCheckLive, xCheckLive};

   ////////////////////////////////////////////////////////////////////////////
   // Read decode

   reg [7:0] next_readData;

   always @* begin
      case (readAddr)
         `ADDR_IDENT: next_readData = powerControl ? `IDENT_VALUE : `BYTE_ZERO;
         `ADDR_RSVD: next_readData = `BYTE_ZERO;
         `ADDR_X_LOW: next_readData = {xView[4:0], 2'b00, checkView[0]};
         `ADDR_X_HIGH: next_readData = xView[12:5];
         `ADDR_Y_LOW: next_readData = {yView[4:0], 2'b00, checkView[1]};
         `ADDR_Y_HIGH: next_readData = yView[12:5];
         `ADDR_Z_LOW: next_readData = {zView[6:0], checkView[2]};
         `ADDR_Z_HIGH: next_readData = zView[14:7];
         `ADDR_R_LOW: next_readData = {rView[5:0], 1'b0, readyStatus};
         `ADDR_R_HIGH: next_readData = rView[13:6];
         // Bit 7 overrun, 6 overflow, 5..3 high z/y/x, 2..0 low z/y/x
         `ADDR_INT_FLAGS: next_readData = intStatus;
         default: next_readData = `BYTE_ZERO;
      endcase
   end

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         readData <= `BYTE_ZERO;
      end else if (readStrobe) begin
         readData <= next_readData;
      end
   end

   assign suspended = ~powerControl;

endmodule

// [test/readout_monitor.sv]
// Port checks for the result readout.
// Bound into the readout module by bind below.
module readout_monitor (
   // Clock and reset
   input wire core_clk,
   input wire rst_b,
   // Status and read port
   input wire powerControl,
   input wire zEnable,
   input wire readyStatus,
   input wire [7:0] intStatus,
   input wire suspended,
   input wire readStrobe,
   input wire [7:0] readAddr,
   input wire [7:0] readData
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   property p_ident;
      readStrobe && readAddr == 8'h40 && !powerControl |=> readData == 8'h0;
   endproperty
   a_ident: assert property (p_ident) else $error("ident");
   property p_rsvd;
      readStrobe && readAddr == 8'h41 |=> readData == 8'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved");
   property p_zero;
      readStrobe && (readAddr == 8'h42 || readAddr == 8'h44) |=> readData[2:1] == 2'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("fixed zero");
   property p_ready;
      readStrobe && readAddr == 8'h48 |=> readData[1:0] == {1'h0, $past(readyStatus)};
   endproperty
   a_ready: assert property (p_ready) else $error("ready");
   property p_flags;
      readStrobe && readAddr == 8'h4A |=> readData == $past(intStatus);
   endproperty
   a_flags: assert property (p_flags) else $error("flags");
   property p_rzero;
      (!zEnable) [*2] ##0 (readStrobe && readAddr == 8'h49) |=> readData == 8'h0;
   endproperty
   a_rzero: assert property (p_rzero) else $error("resistance");
   property p_power;
      suspended == !powerControl;
   endproperty
   a_power: assert property (p_power) else $error("power");
   property p_hold;
      !readStrobe |=> $stable(readData);
   endproperty
   a_hold: assert property (p_hold) else $error("hold");
   c_off: cover property (readStrobe && readAddr == 8'h40 && !powerControl);
   c_zoff: cover property (!zEnable && readStrobe && readAddr == 8'h49);
   c_flags: cover property (readStrobe && readAddr == 8'h4A);
endmodule
bind magnetometer_result_readout readout_monitor mon_u (.*);

// [test/host_reader.sv]
// Host model: one register read at a time.
// Assumes the answer stands one cycle after the strobe edge.
module host_reader (
   // Read port
   input wire core_clk,
   output logic readStrobe = 1'h0,
   output logic [7:0] readAddr = 8'hFF,
   input wire [7:0] readData
);
   timeunit 1ns;
   timeprecision 1ns;
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      readStrobe = 1'h1;
      readAddr = a;
      @(negedge core_clk);
      readStrobe = 1'h0;
      // Flipped so a stale decode shows
      readAddr = ~a;
      d = readData;
   endtask
endmodule

// [test/tb.sv]
// Bench: register table reads, then edge cases.
// Assumes the host model and bound monitor compile with it.
`include "result_readout_defines.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'h0, rst_b = 1'h0, powerControl = 1'h1, readyStatus = 1'h1;
   logic xEnable = 1'h1, yEnable = 1'h1, zEnable = 1'h1, burstActive = 1'h0;
   logic sampleStrobe = 1'h0, checkStrobe = 1'h0, xCheck = 1'h0, yCheck = 1'h1, zCheck = 1'h0;
   logic [12:0] xSample = 13'h1ABC, ySample = 13'h0F35;
   logic [14:0] zSample = 15'h1234;
   logic [13:0] rSample = 14'h2D3C;
   logic [7:0] intStatus = 8'hC3, d, rows [11];
   wire readStrobe, suspended;
   wire [7:0] readAddr, readData;
   int n_errors = 0, check_count = 0, cycles = 0;
   always #25 core_clk = ~core_clk;
   magnetometer_result_readout dut_u (.*);
   host_reader host_u (.*);
   task automatic check(input string nm, input logic [7:0] e, g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic stop_test;
      if (n_errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      @(negedge core_clk);
      s = 1'h1;
      @(negedge core_clk);
      s = 1'h0;
   endtask
   // Run needs under 100 cycles
   always @(negedge core_clk)
      if (++cycles > 500) begin
         n_errors++;
         stop_test;
      end
   initial begin
      rows = '{`IDENT_VALUE, 8'h0, {xSample[4:0], 3'h0}, xSample[12:5], {ySample[4:0], 3'h1},
         ySample[12:5], {zSample[6:0], 1'h0}, zSample[14:7], {rSample[5:0], 2'h1},
         rSample[13:6], intStatus};
      repeat (6) @(negedge core_clk);
      rst_b = 1'h1;
      host_u.rd(8'h46, d);
      check("z low", 8'h01, d);
      pulse(checkStrobe);
      pulse(sampleStrobe);
      foreach (rows[i]) begin
         host_u.rd(8'(8'h40 + i), d);
         check("table", rows[i], d);
      end
      // Burst held open: a sample landing mid-burst must stay hidden
      @(negedge core_clk);
      burstActive = 1'h1;
      ySample = 13'h0;
      pulse(sampleStrobe);
      host_u.rd(8'h45, d);
      check("y burst", rows[5], d);
      @(negedge core_clk);
      burstActive = 1'h0;
      host_u.rd(8'h45, d);
      check("y after burst", 8'h00, d);
      xEnable = 1'h0;
      zEnable = 1'h0;
      xSample = 13'h0;
      pulse(sampleStrobe);
      host_u.rd(8'h43, d);
      check("x kept", rows[3], d);
      host_u.rd(8'h49, d);
      check("r high", 8'h0, d);
      // Reset again in mid-run
      @(negedge core_clk);
      rst_b = 1'h0;
      @(negedge core_clk);
      check("reset data", 8'h00, readData);
      rst_b = 1'h1;
      host_u.rd(8'h46, d);
      check("z low again", 8'h01, d);
      powerControl = 1'h0;
      host_u.rd(8'h40, d);
      check("ident off", 8'h0, d);
      // Samples in suspend must not land
      yEnable = 1'h1;
      ySample = 13'h1FFF;
      pulse(sampleStrobe);
      host_u.rd(8'h45, d);
      check("y suspended", 8'h00, d);
      check("suspended", 8'h01, {7'h0, suspended});
      stop_test;
   end
endmodule
